// [rtl/debug_lock_auth_regs.sv]
// Purpose: software lock, lock status, permission report and component kind of the debug unit
// Assumes: register port with zero wait states; debug reset drives rst; block sits in the debug power domain
// Notes: protected register writes of the wider debug unit are gated by prot_wr_grant
//
// Operation
// - a full 32-bit write of the unlock key to the lock access register clears the lock.
// - writing any other value to the lock access register sets the lock.
// - while locked, writes to the protected debug registers are ignored.
// - the lock access register resets to zero, which is not the key.
// - lock status bit 2 reads zero, bit 0 reads one, bits 31 to 3 are reserved.
// - lock status bit 1 shows the lock, 0 meaning writes allowed and 1 meaning writes ignored.
// - the lock is set by debug reset.
// - reading lock status with the top address bit set returns zero.
// - the lock state lives in the debug power domain and survives core power-down.
// - permission bit 7 reads one, bit 6 is (inv or noninv) and (sec inv or sec noninv), bits 31 to 8 read zero.
// - permission bit 5 reads one, bit 4 is inv and sec inv.
// - permission bits 3 and 1 read one, bit 2 is inv or noninv, bit 0 is inv.
// - component kind holds sub type in bits 7 to 4 and main class in bits 3 to 0, upper bits reserved.
// - component kind reads sub type 1 and main class 5, upper bits zero.

`timescale 1ns/100ps

// ==========================================================================
// top
module debug_lock_auth_regs (
  // clock and debug reset
  input wire logic clk_sys,
  input wire logic rst,
  // debug register port
  input wire dbg_lock_pkg::apb_req_t bus_req,
  input wire logic debug_addr_bit_top,
  output logic [dbg_lock_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // permission pins
  input wire logic invasive_enable_in,
  input wire logic noninvasive_enable_in,
  input wire logic secure_invasive_enable_in,
  input wire logic secure_noninvasive_enable_in,
  // protected register write gate
  input wire logic prot_wr_req,
  output logic prot_wr_grant,
  output logic lock_active
);

  // ========================================================================
  // decode
  logic setup_phase;
  logic access_phase;
  logic hit_key;
  logic hit_lsr;
  logic hit_auth;
  logic hit_kind;
  logic key_write;
  logic full_key;

  assign setup_phase = bus_req.sel && !bus_req.enable;
  assign access_phase = bus_req.sel && bus_req.enable;
  assign hit_key = (bus_req.addr == dbg_lock_pkg::OFS_LOCK_ACCESS_KEY);
  assign hit_lsr = (bus_req.addr == dbg_lock_pkg::OFS_LOCK_STATE_REPORT);
  assign hit_auth = (bus_req.addr == dbg_lock_pkg::OFS_DEBUG_PERMISSION_REPORT);
  assign hit_kind = (bus_req.addr == dbg_lock_pkg::OFS_DEBUG_COMPONENT_KIND);
  // writes from the top-address-bit path have no defined effect, so they are dropped
  assign key_write = access_phase && bus_req.write && hit_key && !debug_addr_bit_top;
  assign full_key = (bus_req.wdata == dbg_lock_pkg::UNLOCK_KEY) && (bus_req.strb == dbg_lock_pkg::STRB_FULL);

  // ========================================================================
  // permission pins
  dbg_lock_pkg::debug_enables_t en_raw;
  dbg_lock_pkg::debug_enables_t en_sync;

  assign en_raw = '{invasive: invasive_enable_in, noninvasive: noninvasive_enable_in,
                    secure_invasive: secure_invasive_enable_in, secure_noninvasive: secure_noninvasive_enable_in};

  pin_sync3 #(
    .WIDTH($bits(dbg_lock_pkg::debug_enables_t))
  ) u_pin_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .async_in(en_raw),
    .sync_out(en_sync)
  );

  // ========================================================================
  // lock state
  logic [dbg_lock_pkg::DATA_W-1:0] key_r;
  logic locked_r;

  // debug reset only; core power-down never reaches these flops
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      key_r <= dbg_lock_pkg::KEY_RESET;
    end else if (key_write) begin
      key_r <= bus_req.wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      locked_r <= dbg_lock_pkg::LOCKED_RESET;
    end else if (key_write) begin
      locked_r <= !full_key;
    end
  end

  assign lock_active = locked_r;
  assign prot_wr_grant = prot_wr_req && !locked_r;

  // ========================================================================
  // read values
  logic [dbg_lock_pkg::DATA_W-1:0] lsr_val;
  logic [dbg_lock_pkg::DATA_W-1:0] auth_val;
  logic [dbg_lock_pkg::DATA_W-1:0] kind_val;

  always_comb begin
    lsr_val = '0;
    lsr_val[dbg_lock_pkg::LSR_IMPL_BIT] = dbg_lock_pkg::LSR_IMPL_VAL;
    lsr_val[dbg_lock_pkg::LSR_WIDTH_BIT] = dbg_lock_pkg::LSR_WIDTH_VAL;
    lsr_val[dbg_lock_pkg::LSR_LOCKED_BIT] = locked_r;
  end

  always_comb begin
    auth_val = '0;
    auth_val[dbg_lock_pkg::AUTH_S_NONINV_IMPL] = dbg_lock_pkg::AUTH_IMPL_VAL;
    auth_val[dbg_lock_pkg::AUTH_S_NONINV_EN] = (en_sync.invasive || en_sync.noninvasive)
      && (en_sync.secure_invasive || en_sync.secure_noninvasive);
    auth_val[dbg_lock_pkg::AUTH_S_INV_IMPL] = dbg_lock_pkg::AUTH_IMPL_VAL;
    auth_val[dbg_lock_pkg::AUTH_S_INV_EN] = en_sync.invasive && en_sync.secure_invasive;
    auth_val[dbg_lock_pkg::AUTH_NS_NONINV_IMPL] = dbg_lock_pkg::AUTH_IMPL_VAL;
    auth_val[dbg_lock_pkg::AUTH_NS_NONINV_EN] = en_sync.invasive || en_sync.noninvasive;
    auth_val[dbg_lock_pkg::AUTH_NS_INV_IMPL] = dbg_lock_pkg::AUTH_IMPL_VAL;
    auth_val[dbg_lock_pkg::AUTH_NS_INV_EN] = en_sync.invasive;
  end

  always_comb begin
    kind_val = '0;
    kind_val[dbg_lock_pkg::KIND_SUB_LSB +: 4] = dbg_lock_pkg::KIND_SUB_CORE;
    kind_val[dbg_lock_pkg::KIND_CLASS_LSB +: 4] = dbg_lock_pkg::KIND_CLASS_DEBUG;
  end

  // ========================================================================
  // read data, captured in the setup phase so it comes from a flop
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prdata <= '0;
    end else if (setup_phase) begin
      if (bus_req.write) begin
        prdata <= '0;
      end else if (hit_lsr) begin
        prdata <= debug_addr_bit_top ? '0 : lsr_val;
      end else if (hit_auth) begin
        prdata <= auth_val;
      end else if (hit_kind) begin
        prdata <= kind_val;
      end else begin
        prdata <= '0;
      end
    end
  end

  // zero wait states; unmapped and write-only reads answer zero without error
  assign pready = 1'h1;
  assign pslverr = 1'h0;

  // ========================================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  logic rd_lsr;
  logic rd_lsr_top;
  logic rd_auth;
  logic rd_kind;
  assign rd_lsr = setup_phase && !bus_req.write && hit_lsr && !debug_addr_bit_top;
  assign rd_lsr_top = setup_phase && !bus_req.write && hit_lsr && debug_addr_bit_top;
  assign rd_auth = setup_phase && !bus_req.write && hit_auth;
  assign rd_kind = setup_phase && !bus_req.write && hit_kind;

  property p_unlock;
    key_write && full_key |=> !locked_r && !lock_active;
  endproperty
  a_unlock: assert property (p_unlock) else $error("key write did not unlock");

  property p_relock;
    key_write && (bus_req.wdata != dbg_lock_pkg::UNLOCK_KEY) |=> locked_r;
  endproperty
  a_relock: assert property (p_relock) else $error("non-key write did not lock");

  property p_ignore;
    prot_wr_req && locked_r |-> !prot_wr_grant;
  endproperty
  a_ignore: assert property (p_ignore) else $error("protected write granted while locked");

  property p_reset_state;
    $fell(rst) |-> locked_r && (key_r == dbg_lock_pkg::KEY_RESET);
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("lock state wrong after reset");

  property p_lsr_read;
    rd_lsr |=> prdata == {29'h0, dbg_lock_pkg::LSR_WIDTH_VAL, $past(locked_r), dbg_lock_pkg::LSR_IMPL_VAL};
  endproperty
  a_lsr_read: assert property (p_lsr_read) else $error("lock status read wrong");

  property p_lsr_top;
    rd_lsr_top |=> prdata == '0;
  endproperty
  a_lsr_top: assert property (p_lsr_top) else $error("lock status via top bit not zero");

  property p_auth;
    rd_auth |=> prdata == {24'h0, 1'h1, ($past(en_sync.invasive) || $past(en_sync.noninvasive))
      && ($past(en_sync.secure_invasive) || $past(en_sync.secure_noninvasive)), 1'h1,
      $past(en_sync.invasive) && $past(en_sync.secure_invasive), 1'h1,
      $past(en_sync.invasive) || $past(en_sync.noninvasive), 1'h1, $past(en_sync.invasive)};
  endproperty
  a_auth: assert property (p_auth) else $error("permission report wrong");

  property p_kind;
    rd_kind |=> prdata == 32'h00000015;
  endproperty
  a_kind: assert property (p_kind) else $error("component kind wrong");

  property p_narrow;
    key_write && (bus_req.strb != dbg_lock_pkg::STRB_FULL) |=> locked_r ##1 (locked_r || key_write);
  endproperty
  a_narrow: assert property (p_narrow) else $error("narrow key write unlocked");

  c_unlock: cover property (locked_r ##1 !locked_r);
  c_relock: cover property (!locked_r ##1 locked_r);
  c_grant: cover property (prot_wr_grant);
  c_auth_read: cover property (rd_auth ##1 prdata[dbg_lock_pkg::AUTH_S_INV_EN]);

endmodule // debug_lock_auth_regs

// [rtl/pin_sync3.sv]
// Purpose: three-stage synchroniser for asynchronous level inputs
// Assumes: inputs are slow levels from pins
// Notes: a change is taken once stages two and three agree

`timescale 1ns/100ps

// ==========================================================================
// synchroniser
module pin_sync3 #(
  parameter int WIDTH = 4
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_r;
  logic [WIDTH-1:0] stage2_r;
  logic [WIDTH-1:0] stage3_r;

  // stage one is read only by stage two, so metastability cannot leak
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stage1_r <= '0;
      stage2_r <= '0;
      stage3_r <= '0;
    end else begin
      stage1_r <= async_in;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
    end
  end

  // hold the last agreed value while the two late stages differ
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync_out <= '0;
    end else begin
      sync_out <= ((stage2_r ~^ stage3_r) & stage3_r) | ((stage2_r ^ stage3_r) & sync_out);
    end
  end

endmodule // pin_sync3

// [shared/dbg_lock_pkg.sv]
// Purpose: constants and carrier types for the debug lock and identification registers
// Assumes: 32-bit register bus with 12-bit word-aligned byte addresses
// Notes: register offsets in this block are fixed here and used by the design only by name

// ==========================================================================
// package
package dbg_lock_pkg;

  // ========================================================================
  // bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;
  localparam logic [STRB_W-1:0] STRB_FULL = 4'hF;

  // ========================================================================
  // register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFS_LOCK_ACCESS_KEY = 12'hFB0;
  localparam logic [ADDR_W-1:0] OFS_LOCK_STATE_REPORT = 12'hFB4;
  localparam logic [ADDR_W-1:0] OFS_DEBUG_PERMISSION_REPORT = 12'hFB8;
  localparam logic [ADDR_W-1:0] OFS_DEBUG_COMPONENT_KIND = 12'hFCC;

  // ========================================================================
  // lock access key
  localparam logic [DATA_W-1:0] UNLOCK_KEY = 32'hC5ACCE55;
  localparam logic [DATA_W-1:0] KEY_RESET = 32'h00000000;
  localparam logic LOCKED_RESET = 1'h1;

  // ========================================================================
  // lock state report fields
  localparam int LSR_IMPL_BIT = 0;
  localparam int LSR_LOCKED_BIT = 1;
  localparam int LSR_WIDTH_BIT = 2;
  localparam logic LSR_IMPL_VAL = 1'h1;
  localparam logic LSR_WIDTH_VAL = 1'h0;

  // ========================================================================
  // debug permission report fields
  localparam int AUTH_NS_INV_EN = 0;
  localparam int AUTH_NS_INV_IMPL = 1;
  localparam int AUTH_NS_NONINV_EN = 2;
  localparam int AUTH_NS_NONINV_IMPL = 3;
  localparam int AUTH_S_INV_EN = 4;
  localparam int AUTH_S_INV_IMPL = 5;
  localparam int AUTH_S_NONINV_EN = 6;
  localparam int AUTH_S_NONINV_IMPL = 7;
  localparam logic AUTH_IMPL_VAL = 1'h1;

  // ========================================================================
  // debug component kind fields
  localparam int KIND_SUB_LSB = 4;
  localparam int KIND_CLASS_LSB = 0;
  localparam logic [3:0] KIND_SUB_CORE = 4'h1;
  localparam logic [3:0] KIND_CLASS_DEBUG = 4'h5;

  // ========================================================================
  // carriers
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [STRB_W-1:0] strb;
  } apb_req_t;

  typedef struct packed {
    logic invasive;
    logic noninvasive;
    logic secure_invasive;
    logic secure_noninvasive;
  } debug_enables_t;

endpackage

// [testbench/apb_debugger.sv]
// Purpose: external debugger model driving the debug register port
// Assumes: zero or more wait states, pready sampled at the rising edge
// Notes: released address, data, strobe and top-bit lines carry the inverse of their last value; write keeps its last value

`timescale 1ns/100ps

// ==========================================================================
// debugger
module apb_debugger (
  // clock
  input wire logic clk_sys,
  // bus
  output dbg_lock_pkg::apb_req_t bus_req,
  output logic debug_addr_bit_top,
  input wire logic [dbg_lock_pkg::DATA_W-1:0] prdata,
  input wire logic pready
);
  initial begin
    bus_req <= '0;
    debug_addr_bit_top <= 1'b0;
  end

  // only the bus port is used, never the coprocessor path
  task automatic xfer(input logic wr, input logic top, input logic [11:0] a,
                      input logic [31:0] wd, input logic [3:0] s, output logic [31:0] rd);
    int n;
    @(posedge clk_sys);
    bus_req <= '{sel: 1'b1, enable: 1'b0, write: wr, addr: a, wdata: wd, strb: s};
    debug_addr_bit_top <= top;
    @(posedge clk_sys);
    bus_req.enable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    bus_req.sel <= 1'b0;
    bus_req.enable <= 1'b0;
    bus_req.addr <= ~a;
    bus_req.wdata <= ~wd;
    bus_req.strb <= ~s;
    debug_addr_bit_top <= ~top;
  endtask
endmodule // apb_debugger

// [testbench/debug_lock_auth_regs_bench.sv]
// Purpose: self-checking bench for the debug lock and identification registers
// Assumes: 100 MHz clock, synchronous active-high reset
// Notes: pins get five cycles to pass the three-flop synchroniser before a read

`timescale 1ns/100ps

// ==========================================================================
// bench
module debug_lock_auth_regs_bench;
  logic clk_sys;
  logic rst;
  dbg_lock_pkg::apb_req_t bus_req;
  logic debug_addr_bit_top;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  dbg_lock_pkg::debug_enables_t en;
  logic prot_wr_req;
  logic prot_wr_grant;
  logic lock_active;
  int n_mismatch = 0;
  int comparisons = 0;
  logic [31:0] d;
  logic [3:0] strbs [4] = '{4'h1, 4'h7, 4'hE, 4'h8};

  debug_lock_auth_regs dut (
    .clk_sys(clk_sys), .rst(rst), .bus_req(bus_req), .debug_addr_bit_top(debug_addr_bit_top),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .invasive_enable_in(en.invasive), .noninvasive_enable_in(en.noninvasive),
    .secure_invasive_enable_in(en.secure_invasive), .secure_noninvasive_enable_in(en.secure_noninvasive),
    .prot_wr_req(prot_wr_req), .prot_wr_grant(prot_wr_grant), .lock_active(lock_active)
  );

  apb_debugger dbg (
    .clk_sys(clk_sys), .bus_req(bus_req), .debug_addr_bit_top(debug_addr_bit_top),
    .prdata(prdata), .pready(pready)
  );

  // ========================================================================
  // helpers
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s = 4'hF,
                    input logic top = 1'b0);
    logic [31:0] x;
    dbg.xfer(1'b1, top, a, v, s, x);
  endtask

  task automatic rd(input logic [11:0] a, input logic top = 1'b0);
    dbg.xfer(1'b0, top, a, 32'h0, 4'h0, d);
  endtask

  // lock seen three ways: flag, write gate and status register
  task automatic lockchk(input logic lk);
    #1;
    check({31'h0, lock_active}, {31'h0, lk});
    check({31'h0, prot_wr_grant}, {31'h0, prot_wr_req & ~lk});
    rd(dbg_lock_pkg::OFS_LOCK_STATE_REPORT);
    check(d, {29'h0, 1'b0, lk, 1'b1});
  endtask

  function automatic logic [31:0] auth(input dbg_lock_pkg::debug_enables_t e);
    auth = {24'h0, 1'b1, (e.invasive | e.noninvasive) & (e.secure_invasive | e.secure_noninvasive),
            1'b1, e.invasive & e.secure_invasive, 1'b1, e.invasive | e.noninvasive, 1'b1, e.invasive};
  endfunction

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #50000;
    n_mismatch++;
    summarize();
  end

  // ========================================================================
  // tests
  initial begin
    rst <= 1'b1;
    prot_wr_req <= 1'b0;
    en <= '0;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    prot_wr_req <= 1'b1;
    lockchk(1'b1);
    rd(dbg_lock_pkg::OFS_LOCK_ACCESS_KEY);
    check(d, 32'h0);
    rd(dbg_lock_pkg::OFS_DEBUG_COMPONENT_KIND);
    check(d, 32'h00000015);
    rd(12'hFC0);
    check(d, 32'h0);
    check({31'h0, pslverr}, 32'h0);
    check({31'h0, pready}, 32'h1);
    // top-bit key write is dropped by design choice
    wr(dbg_lock_pkg::OFS_LOCK_ACCESS_KEY, dbg_lock_pkg::UNLOCK_KEY, 4'hF, 1'b1);
    lockchk(1'b1);
    wr(dbg_lock_pkg::OFS_LOCK_ACCESS_KEY, dbg_lock_pkg::UNLOCK_KEY);
    lockchk(1'b0);
    // with no request pending the gate must stay shut even when unlocked
    prot_wr_req <= 1'b0;
    lockchk(1'b0);
    prot_wr_req <= 1'b1;
    rd(dbg_lock_pkg::OFS_LOCK_STATE_REPORT, 1'b1);
    check(d, 32'h0);
    wr(dbg_lock_pkg::OFS_DEBUG_COMPONENT_KIND, 32'hFFFFFFFF);
    rd(dbg_lock_pkg::OFS_DEBUG_COMPONENT_KIND);
    check(d, 32'h00000015);
    wr(dbg_lock_pkg::OFS_LOCK_ACCESS_KEY, dbg_lock_pkg::UNLOCK_KEY ^ 32'h00000001);
    lockchk(1'b1);
    // a narrow key write must relock even from the unlocked state
    for (int i = 0; i < 4; i++) begin
      wr(dbg_lock_pkg::OFS_LOCK_ACCESS_KEY, dbg_lock_pkg::UNLOCK_KEY);
      lockchk(1'b0);
      wr(dbg_lock_pkg::OFS_LOCK_ACCESS_KEY, dbg_lock_pkg::UNLOCK_KEY, strbs[i]);
      lockchk(1'b1);
    end
    // mid-run debug reset relocks
    wr(dbg_lock_pkg::OFS_LOCK_ACCESS_KEY, dbg_lock_pkg::UNLOCK_KEY);
    lockchk(1'b0);
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    lockchk(1'b1);
    // every permission pin combination
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_sys);
      en <= i[3:0];
      repeat (5) @(posedge clk_sys);
      rd(dbg_lock_pkg::OFS_DEBUG_PERMISSION_REPORT);
      check(d, auth(i[3:0]));
    end
    summarize();
  end
endmodule // debug_lock_auth_regs_bench
